// File: rtl/ciq_cfg.svh
// Offsets, field positions, reset values and timing counts.
// Included by the design file only, not by the package; definitions only.
`ifndef CIQ_CFG_SVH
`define CIQ_CFG_SVH
`define CIQ_OFF_GLOBAL_CONTROL   8'h00
`define CIQ_OFF_HCFG    8'h04
`define CIQ_OFF_HSTS    8'h08
`define CIQ_OFF_TXSTS   8'h0C
`define CIQ_OFF_FLAGS   8'h10
`define CIQ_OFF_ERRIE   8'h14
`define CIQ_OFF_MODE    8'h18
`define CIQ_OFF_BITCYC  8'h1C
`define CIQ_GC_LOSTIE   0
`define CIQ_GC_GREQ     2:1
`define CIQ_GC_CREQ     4:3
`define CIQ_HC_EN       0
`define CIQ_HC_IE       1
`define CIQ_HC_MODE     2
`define CIQ_HS_CNT      3:0
`define CIQ_HS_FLAG     4
`define CIQ_HS_FULL     5
`define CIQ_HS_POP      8
`define CIQ_RST_BITCYC  16'h0028
`define CIQ_RST_ERRIE   11'h000
`define CIQ_HIST_DEPTH  8
`define CIQ_HIST_THR    6
`define CIQ_FRAME_BITS  160
`define CIQ_T_SLP       3
`define CIQ_T_G_RUN     10
`define CIQ_T_G_HOP     3
`define CIQ_B_G_RST     2
`define CIQ_F_G_HLT     3
`define CIQ_B_C_HLT     3
`define CIQ_B_C_OP      4
`define CIQ_B_C_RST     2
`define CIQ_F_C_HLT     2
`define CIQ_N_SLP       (`CIQ_T_SLP - 2)
`define CIQ_N_G_RUN     (`CIQ_T_G_RUN - 2)
`define CIQ_N_G_HOP     (`CIQ_T_G_HOP - 2)
`define CIQ_N_G_RST     (`CIQ_B_G_RST - 1)
`define CIQ_N_C_HLT     (`CIQ_B_C_HLT - 1)
`define CIQ_N_C_OP      (`CIQ_B_C_OP - 1)
`define CIQ_N_C_RST     (`CIQ_B_C_RST - 1)
`endif

// File: rtl/ciq_pkg.sv
// Types shared by the interrupt and mode block.
// Assumes nothing beyond a SystemVerilog compiler.
package ciq_pkg;
   typedef enum logic [1:0] {
      ciq_md_reset,
      ciq_md_halt,
      ciq_md_oper,
      ciq_md_sleep
   } ciq_mode_t;
endpackage : ciq_pkg

// File: rtl/ciq_irq_mode.sv
// CAN interrupt aggregation, history buffer flags and mode timing.
// Assumes an APB master on clk_in, one-cycle event pulses and
// request levels held by their owning blocks, all synchronous.
// How it works
// - History flag feeds the transmit interrupt when its enable is set
// - Transmit interrupt ORs four sources, all shown in tx status
// - Disabling the history buffer leaves its flag set
// - Per-buffer history enable gates flag onto transmit interrupt
// - Mode bit picks flag at six entries or at every entry
// - History overflow raises global error when lost enable set
// - One global control bit enables the entry-lost interrupt
// - Global error ORs length, FIFO lost, entry lost, payload flags
// - Any receive FIFO request raises global receive FIFO interrupt
// - Any receive buffer request raises global receive buffer irq
// - Shared FIFO receive request raises its channel interrupt
// - Channel error interrupt ORs eleven enabled error flags
// - Falling edge on bus receive line sets the wakeup flag
// - ECC correction or double error raises the ECC interrupt
// - Global transitions finish within their cycle or bit limits
// - Global operating to halt ends within three frames
// - Channel transitions finish within their cycle or bit limits
// - Channel halt/op within four bits, op to halt two frames
// - Bit and frame times follow channel 0 nominal bit rate
// - History buffer holds eight; a ninth store is overflow
`include "ciq_cfg.svh"
module ciq_irq_mode #(
   parameter int HIST_DEPTH = `CIQ_HIST_DEPTH,
   parameter int HIST_THR   = `CIQ_HIST_THR,
   parameter int N_RXF      = 2,
   parameter int N_RXB      = 16,
   parameter int FRAME_BITS = `CIQ_FRAME_BITS
) (
   input  wire logic             clk_in,
   input  wire logic             sys_rst_in,
   input  wire logic [7:0]       paddr_in,
   input  wire logic             psel_in,
   input  wire logic             penable_in,
   input  wire logic             pwrite_in,
   input  wire logic [31:0]      pwdata_in,
   output logic      [31:0]      prdata_out,
   output logic                  pready_out,
   output logic                  pslverr_out,
   input  wire logic             tx_done_req_in,
   input  wire logic             tx_abort_req_in,
   input  wire logic             cf_tx_req_in,
   input  wire logic             hist_store_in,
   input  wire logic             dlc_err_in,
   input  wire logic             fifo_lost_in,
   input  wire logic             payload_ovf_in,
   input  wire logic [10:0]      chan_err_ev_in,
   input  wire logic             ecc_sec_in,
   input  wire logic             ecc_ded_in,
   input  wire logic             can_rx_in,
   input  wire logic             bus_idle_in,
   input  wire logic [N_RXF-1:0] rx_fifo_req_in,
   input  wire logic [N_RXB-1:0] rx_buf_req_in,
   input  wire logic             cf_rx_req_in,
   output logic                  irq_rx_fifo_out,
   output logic                  irq_rx_buf_out,
   output logic                  irq_glb_err_out,
   output logic                  irq_tx_out,
   output logic                  irq_cf_rx_out,
   output logic                  irq_ch_err_out,
   output logic                  irq_wakeup_out,
   output logic                  irq_ecc_out,
   output logic      [1:0]       glb_mode_out,
   output logic      [1:0]       chan_mode_out
);
   localparam int HW = $clog2(HIST_DEPTH + 1);
   localparam logic [HW-1:0] DEP = HW'(HIST_DEPTH);
   localparam logic [HW-1:0] THR = HW'(HIST_THR);
   localparam logic [9:0] N_SLP  = 10'(`CIQ_N_SLP);
   localparam logic [9:0] N_GRUN = 10'(`CIQ_N_G_RUN);
   localparam logic [9:0] N_GHOP = 10'(`CIQ_N_G_HOP);
   localparam logic [9:0] N_GRST = 10'(`CIQ_N_G_RST);
   localparam logic [9:0] N_GFRM = 10'((`CIQ_F_G_HLT - 1) * FRAME_BITS);
   localparam logic [9:0] N_CHLT = 10'(`CIQ_N_C_HLT);
   localparam logic [9:0] N_COP  = 10'(`CIQ_N_C_OP);
   localparam logic [9:0] N_CRST = 10'(`CIQ_N_C_RST);
   localparam logic [9:0] N_CFRM = 10'((`CIQ_F_C_HLT - 1) * FRAME_BITS);

   logic                setup;
   logic                wr;
   logic                hit;
   logic [31:0]         rdata;
   logic                lost_ie;
   ciq_pkg::ciq_mode_t  req [2];
   ciq_pkg::ciq_mode_t  mode [2];
   ciq_pkg::ciq_mode_t  tgt [2];
   logic [1:0]          busy;
   logic [1:0]          bitk;
   logic [1:0]          frm;
   logic [9:0]          cnt [2];
   logic                hben;
   logic                hie;
   logic                hmode;
   logic [HW-1:0]       hcnt;
   logic                hflag;
   logic                hfull;
   logic                store;
   logic                pop;
   logic                lost_ev;
   logic                hist_set;
   logic [10:0]         err_ie;
   logic [15:0]         bit_cyc;
   logic [15:0]         bcnt;
   logic                bit_tick;
   logic                rx_prev;
   logic [17:0]         ev;
   logic [17:0]         flg;

   // APB: zero wait states, read data captured in the setup cycle
   assign setup       = psel_in && !penable_in;
   assign wr          = psel_in && penable_in && pwrite_in;
   assign pready_out  = 1'b1;
   assign pslverr_out = psel_in && penable_in && !hit;

   always_comb begin
      rdata = 32'h0000_0000;
      hit   = 1'b1;
      case (paddr_in)
         `CIQ_OFF_GLOBAL_CONTROL: begin
            rdata[`CIQ_GC_LOSTIE] = lost_ie;
            rdata[`CIQ_GC_GREQ]   = req[0];
            rdata[`CIQ_GC_CREQ]   = req[1];
         end
         `CIQ_OFF_HCFG: begin
            rdata[`CIQ_HC_EN]   = hben;
            rdata[`CIQ_HC_IE]   = hie;
            rdata[`CIQ_HC_MODE] = hmode;
         end
         `CIQ_OFF_HSTS: begin
            rdata[`CIQ_HS_CNT]  = 4'(hcnt);
            rdata[`CIQ_HS_FLAG] = hflag;
            rdata[`CIQ_HS_FULL] = hfull;
         end
         `CIQ_OFF_TXSTS: begin
            rdata[3:0] = {hflag, cf_tx_req_in,
                          tx_abort_req_in, tx_done_req_in};
         end
         `CIQ_OFF_FLAGS:  rdata[17:0] = flg;
         `CIQ_OFF_ERRIE:  rdata[10:0] = err_ie;
         `CIQ_OFF_MODE: begin
            rdata[1:0] = mode[0];
            rdata[3:2] = mode[1];
            rdata[5:4] = busy;
         end
         `CIQ_OFF_BITCYC: rdata[15:0] = bit_cyc;
         default:         hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         prdata_out <= 32'h0000_0000;
      end else if (setup) begin
         prdata_out <= rdata;
      end
   end

   // Control registers
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         lost_ie <= 1'b0;
         req[0]  <= ciq_pkg::ciq_md_sleep;
         req[1]  <= ciq_pkg::ciq_md_sleep;
      end else if (wr && paddr_in == `CIQ_OFF_GLOBAL_CONTROL) begin
         lost_ie <= pwdata_in[`CIQ_GC_LOSTIE];
         req[0]  <= ciq_pkg::ciq_mode_t'(pwdata_in[`CIQ_GC_GREQ]);
         req[1]  <= ciq_pkg::ciq_mode_t'(pwdata_in[`CIQ_GC_CREQ]);
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         hben  <= 1'b0;
         hie   <= 1'b0;
         hmode <= 1'b0;
      end else if (wr && paddr_in == `CIQ_OFF_HCFG) begin
         hben  <= pwdata_in[`CIQ_HC_EN];
         hie   <= pwdata_in[`CIQ_HC_IE];
         hmode <= pwdata_in[`CIQ_HC_MODE];
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         err_ie  <= `CIQ_RST_ERRIE;
         bit_cyc <= `CIQ_RST_BITCYC;
      end else if (wr && paddr_in == `CIQ_OFF_ERRIE) begin
         err_ie  <= pwdata_in[10:0];
      end else if (wr && paddr_in == `CIQ_OFF_BITCYC) begin
         bit_cyc <= pwdata_in[15:0];
      end
   end

   // Transmit history occupancy; entries themselves live elsewhere
   assign store = hist_store_in && hben;
   assign pop   = wr && paddr_in == `CIQ_OFF_HSTS
                  && pwdata_in[`CIQ_HS_POP] && hcnt != '0;
   assign hfull = hcnt == DEP;
   assign lost_ev = store && hfull && !pop;
   assign hist_set = store && (hmode || (!pop && hcnt == THR - 1'b1));

   always_ff @(posedge clk_in) begin
      if (sys_rst_in || !hben) begin
         hcnt <= '0;
      end else if (store && !pop && !hfull) begin
         hcnt <= hcnt + 1'b1;
      end else if (pop && !store) begin
         hcnt <= hcnt - 1'b1;
      end
   end

   // Set wins over the software clear; disabling never clears it
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         hflag <= 1'b0;
      end else if (hist_set) begin
         hflag <= 1'b1;
      end else if (wr && paddr_in == `CIQ_OFF_HSTS
                   && pwdata_in[`CIQ_HS_FLAG]) begin
         hflag <= 1'b0;
      end
   end

   // Sticky event flags, cleared by writing ones
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         rx_prev <= 1'b1;
      end else begin
         rx_prev <= can_rx_in;
      end
   end

   assign ev = {ecc_ded_in, ecc_sec_in,
                rx_prev && !can_rx_in,
                chan_err_ev_in, payload_ovf_in, lost_ev,
                fifo_lost_in, dlc_err_in};

   for (genvar i = 0; i < 18; i++) begin : g_flag
      always_ff @(posedge clk_in) begin
         if (sys_rst_in) begin
            flg[i] <= 1'b0;
         end else if (ev[i]) begin
            flg[i] <= 1'b1;
         end else if (wr && paddr_in == `CIQ_OFF_FLAGS && pwdata_in[i]) begin
            flg[i] <= 1'b0;
         end
      end
   end

   // Interrupt outputs, registered for glitch-free levels
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         irq_rx_fifo_out <= 1'b0;
         irq_rx_buf_out  <= 1'b0;
         irq_glb_err_out <= 1'b0;
         irq_tx_out      <= 1'b0;
         irq_cf_rx_out   <= 1'b0;
         irq_ch_err_out  <= 1'b0;
         irq_wakeup_out  <= 1'b0;
         irq_ecc_out     <= 1'b0;
      end else begin
         irq_rx_fifo_out <= |rx_fifo_req_in;
         irq_rx_buf_out  <= |rx_buf_req_in;
         irq_glb_err_out <= flg[0] || flg[1] || flg[3]
                            || (flg[2] && lost_ie);
         irq_tx_out      <= tx_done_req_in || tx_abort_req_in
                            || cf_tx_req_in || (hflag && hie);
         irq_cf_rx_out   <= cf_rx_req_in;
         irq_ch_err_out  <= |(flg[14:4] & err_ie);
         irq_wakeup_out  <= flg[15];
         irq_ecc_out     <= flg[16] || flg[17];
      end
   end

   // Nominal bit tick of channel 0 drives all bit and frame counts
   always_ff @(posedge clk_in) begin
      if (sys_rst_in || bit_tick) begin
         bcnt <= 16'h0000;
      end else begin
         bcnt <= bcnt + 16'h0001;
      end
   end

   assign bit_tick = bcnt + 16'h0001 >= bit_cyc;

   function automatic logic legal(input ciq_pkg::ciq_mode_t f,
                                  input ciq_pkg::ciq_mode_t t);
      return f != t
             && !(f == ciq_pkg::ciq_md_sleep && t != ciq_pkg::ciq_md_reset)
             && !(t == ciq_pkg::ciq_md_sleep && f != ciq_pkg::ciq_md_reset);
   endfunction : legal

   // Returns {bit kind, frame kind, count}
   function automatic logic [11:0] wait_of(input logic ch,
                                          input ciq_pkg::ciq_mode_t f,
                                          input ciq_pkg::ciq_mode_t t);
      logic [11:0] w;
      w = {2'b00, N_SLP};
      case (t)
         ciq_pkg::ciq_md_reset: begin
            if (f != ciq_pkg::ciq_md_sleep) begin
               w = {2'b10, ch ? N_CRST : N_GRST};
            end
         end
         ciq_pkg::ciq_md_halt: begin
            if (f == ciq_pkg::ciq_md_reset) begin
               w = ch ? {2'b10, N_CHLT} : {2'b00, N_GRUN};
            end else begin
               w = {2'b11, ch ? N_CFRM : N_GFRM};
            end
         end
         ciq_pkg::ciq_md_oper: begin
            if (f == ciq_pkg::ciq_md_reset) begin
               w = ch ? {2'b10, N_COP} : {2'b00, N_GRUN};
            end else begin
               w = ch ? {2'b10, N_COP} : {2'b00, N_GHOP};
            end
         end
         default: begin
            w = {2'b00, N_SLP};
         end
      endcase
      return w;
   endfunction : wait_of

   // Unit 0 is the global mode, unit 1 the channel mode
   for (genvar u = 0; u < 2; u++) begin : g_mode
      logic [11:0] w;
      assign w = wait_of(1'(u), mode[u], req[u]);
      always_ff @(posedge clk_in) begin
         if (sys_rst_in) begin
            mode[u] <= ciq_pkg::ciq_md_sleep;
            tgt[u]  <= ciq_pkg::ciq_md_sleep;
            busy[u] <= 1'b0;
            bitk[u] <= 1'b0;
            frm[u]  <= 1'b0;
            cnt[u]  <= 10'h000;
         end else if (!busy[u]) begin
            if (legal(mode[u], req[u])) begin
               busy[u] <= 1'b1;
               tgt[u]  <= req[u];
               bitk[u] <= w[11];
               frm[u]  <= w[10];
               cnt[u]  <= w[9:0];
            end
         end else if (bitk[u] ? bit_tick : 1'b1) begin
            // Halt waits for bus idle, bounded by whole frames
            if (cnt[u] <= 10'h001 || (frm[u] && bus_idle_in)) begin
               mode[u] <= tgt[u];
               busy[u] <= 1'b0;
            end else begin
               cnt[u] <= cnt[u] - 10'h001;
            end
         end
      end
   end

   assign glb_mode_out  = mode[0];
   assign chan_mode_out = mode[1];

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);

   a_tx_irq_or: assert property (
      (tx_done_req_in || tx_abort_req_in || cf_tx_req_in
       || (hflag && hie)) |=> irq_tx_out)
      else $error("transmit irq missing");
   a_tx_hist_gate: assert property (
      (!tx_done_req_in && !tx_abort_req_in && !cf_tx_req_in && !hie)
      |=> !irq_tx_out)
      else $error("history irq not gated");
   a_hist_keep: assert property (
      (hflag && !(wr && paddr_in == `CIQ_OFF_HSTS
                  && pwdata_in[`CIQ_HS_FLAG])) |=> hflag)
      else $error("history flag lost");
   a_hist_six: assert property (
      (store && !hmode && !pop && hcnt == THR - 1'b1) |=> hflag)
      else $error("sixth entry flag missing");
   a_hist_each: assert property (
      (store && hmode) |=> hflag ##1 irq_tx_out || !hie)
      else $error("per-entry flag missing");
   a_hist_lost: assert property (
      (store && hfull && !pop) |=> flg[2] && hcnt == DEP)
      else $error("overflow not flagged");
   a_lost_gate: assert property (
      (!lost_ie && !flg[0] && !flg[1] && !flg[3]) |=> !irq_glb_err_out)
      else $error("entry lost not gated");
   a_wake_edge: assert property (
      ($fell(can_rx_in)) |=> flg[15] ##1 irq_wakeup_out)
      else $error("wakeup edge missed");
   a_ecc_irq: assert property (
      (ecc_sec_in || ecc_ded_in) |=> ##1 irq_ecc_out)
      else $error("ecc irq missing");
   a_sleep_wake: assert property (
      (!busy[0] && mode[0] == ciq_pkg::ciq_md_sleep
       && req[0] == ciq_pkg::ciq_md_reset)
      |-> ##[1:2] mode[0] == ciq_pkg::ciq_md_reset)
      else $error("sleep to reset too slow");
   a_reset_run: assert property (
      (!busy[0] && mode[0] == ciq_pkg::ciq_md_reset
       && req[0] == ciq_pkg::ciq_md_oper)
      |-> ##[1:9] mode[0] == ciq_pkg::ciq_md_oper)
      else $error("reset to operating too slow");
   a_mode_stable: assert property (
      (busy[1] && !$past(busy[1])) |-> $stable(mode[1]))
      else $error("mode moved before completion");

   c_tx_hist: cover property (store && hmode ##1 hflag ##1 irq_tx_out);
   c_overflow: cover property (lost_ev ##2 irq_glb_err_out);
   c_ch_halt: cover property (busy[1] && frm[1] ##[1:400] !busy[1]);
   c_wakeup: cover property ($fell(can_rx_in) ##2 irq_wakeup_out);
endmodule : ciq_irq_mode

// File: verification/ciq_bus_model.sv
// CAN bus as seen through a transceiver: receive level and idle.
// Assumes the bench commands frame traffic and dominant wake pulses.
module ciq_bus_model (
   input  wire logic clk_in,
   input  wire logic busy_in,
   input  wire logic wake_in,
   output logic      can_rx_out,
   output logic      bus_idle_out
);
   logic tgl;
   // Frames toggle the line so a stale level never looks idle
   always_ff @(posedge clk_in) begin
      tgl <= busy_in ? ~tgl : 1'b1;
   end
   // Recessive high when nobody drives
   assign can_rx_out   = busy_in ? tgl : ~wake_in;
   assign bus_idle_out = ~busy_in;
endmodule : ciq_bus_model

// File: verification/tb_can_irq_sources_mode_timing.sv
// Self-checking bench for the CAN interrupt and mode block.
// Assumes the design files and the bus model are compiled first.
module tb_can_irq_sources_mode_timing;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int FB = 10;
   localparam int BC = 4;
   localparam logic [7:0] LVI [8] = '{8'h08, 8'h08, 8'h08, 8'h10,
                                      8'h01, 8'h01, 8'h02, 8'h02};
   logic        clk_in = 1'b0;
   logic        sys_rst_in = 1'b1;
   logic [7:0]  paddr = 8'h00;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [16:0] ev = 17'h00000;
   logic [7:0]  lv = 8'h00;
   logic        busy = 1'b0;
   logic        wake = 1'b0;
   logic        can_rx;
   logic        bus_idle;
   logic [7:0]  irq;
   logic [1:0]  gm;
   logic [1:0]  cm;
   logic [31:0] rd;
   logic        er;
   int          miscompares = 0;
   int          n_compared = 0;
   int          i;

   always #12.5 clk_in = ~clk_in;

   ciq_irq_mode #(.N_RXF(2), .N_RXB(2), .FRAME_BITS(FB)) uut (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .paddr_in(paddr),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .tx_done_req_in(lv[0]),
      .tx_abort_req_in(lv[1]), .cf_tx_req_in(lv[2]),
      .hist_store_in(ev[0]), .dlc_err_in(ev[1]), .fifo_lost_in(ev[2]),
      .payload_ovf_in(ev[3]), .chan_err_ev_in(ev[16:6]),
      .ecc_sec_in(ev[4]), .ecc_ded_in(ev[5]), .can_rx_in(can_rx),
      .bus_idle_in(bus_idle), .rx_fifo_req_in(lv[5:4]),
      .rx_buf_req_in(lv[7:6]), .cf_rx_req_in(lv[3]),
      .irq_rx_fifo_out(irq[0]), .irq_rx_buf_out(irq[1]),
      .irq_glb_err_out(irq[2]), .irq_tx_out(irq[3]),
      .irq_cf_rx_out(irq[4]), .irq_ch_err_out(irq[5]),
      .irq_wakeup_out(irq[6]), .irq_ecc_out(irq[7]),
      .glb_mode_out(gm), .chan_mode_out(cm));

   ciq_bus_model u_bus (.clk_in(clk_in), .busy_in(busy),
      .wake_in(wake), .can_rx_out(can_rx), .bus_idle_out(bus_idle));

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Holds the request until pready is sampled high at an edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         miscompares++;
         $display("CHECK FAILED apb_ready expected 1 seen %b", pready);
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rdc(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask : rdc

   task automatic settle();
      repeat (3) @(posedge clk_in);
      @(negedge clk_in);
   endtask : settle

   task automatic pulse(input int k);
      @(posedge clk_in);
      ev[k] <= 1'b1;
      @(posedge clk_in);
      ev[k] <= 1'b0;
   endtask : pulse

   task automatic bus(input logic b);
      @(posedge clk_in);
      busy <= b;
   endtask : bus

   // Waits a bounded time for the new mode, then reads the status
   task automatic go(input logic [1:0] g, input logic [1:0] c,
                     input int lim);
      int n;
      n = 0;
      wr(8'h00, {27'h0000000, c, g, 1'b0});
      while ((gm !== g || cm !== c) && n <= lim) begin
         @(posedge clk_in);
         @(negedge clk_in);
         n++;
      end
      chk("mode_in_time", 32'h1, {31'h0, n <= lim});
      rdc("mode_status", 8'h18, {28'h0000000, c, g});
   endtask : go

   function automatic int fpos(input int k);
      return k < 4 ? (k == 3 ? 3 : k - 1) : (k < 6 ? k + 12 : k - 2);
   endfunction : fpos

   task automatic report_and_stop();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (8) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      settle();
      chk("irq_reset", 32'h0, 32'(irq));
      rdc("mode_reset", 8'h18, 32'h0F);
      rdc("bitcyc_reset", 8'h1C, 32'h28);
      rdc("errie_reset", 8'h14, 32'h0);
      rdc("unmapped", 8'h24, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, er});
      wr(8'h1C, BC);
      rdc("bitcyc_set", 8'h1C, BC);
      $display("test registers done");
      for (i = 0; i < 8; i++) begin
         @(posedge clk_in);
         lv <= 8'h01 << i;
         settle();
         chk("irq_level", 32'(LVI[i]), 32'(irq));
         rdc("tx_status", 8'h0C, i < 3 ? 32'h1 << i : 32'h0);
         @(posedge clk_in);
         lv <= 8'h00;
         settle();
         chk("irq_level_off", 32'h0, 32'(irq));
      end
      $display("test levels done");
      wr(8'h14, 32'h000007FF);
      for (i = 1; i < 17; i++) begin
         pulse(i);
         settle();
         chk("irq_event", i < 4 ? 32'h04 : i < 6 ? 32'h80 : 32'h20,
             32'(irq));
         rdc("event_flag", 8'h10, 32'h1 << fpos(i));
         wr(8'h10, 32'h1 << fpos(i));
         settle();
         chk("irq_event_off", 32'h0, 32'(irq));
      end
      @(posedge clk_in);
      wake <= 1'b1;
      @(posedge clk_in);
      wake <= 1'b0;
      settle();
      chk("irq_wake", 32'h40, 32'(irq));
      wr(8'h10, 32'h00008000);
      settle();
      chk("irq_wake_off", 32'h0, 32'(irq));
      $display("test events done");
      wr(8'h04, 32'h3);
      repeat (5) pulse(0);
      settle();
      chk("irq_tx_five", 32'h0, 32'(irq));
      pulse(0);
      settle();
      chk("irq_tx_six", 32'h8, 32'(irq));
      rdc("hist_six", 8'h08, 32'h16);
      wr(8'h04, 32'h1);
      settle();
      chk("irq_tx_gated", 32'h0, 32'(irq));
      wr(8'h04, 32'h0);
      rdc("hist_off", 8'h08, 32'h10);
      wr(8'h04, 32'h3);
      settle();
      chk("irq_tx_kept", 32'h8, 32'(irq));
      wr(8'h08, 32'h10);
      settle();
      chk("irq_tx_clear", 32'h0, 32'(irq));
      wr(8'h04, 32'h7);
      pulse(0);
      settle();
      chk("irq_tx_each", 32'h8, 32'(irq));
      repeat (7) pulse(0);
      rdc("hist_full", 8'h08, 32'h38);
      pulse(0);
      rdc("lost_flag", 8'h10, 32'h4);
      settle();
      chk("lost_gated", 32'h8, 32'(irq));
      wr(8'h00, 32'h1F);
      settle();
      chk("lost_irq", 32'hC, 32'(irq));
      wr(8'h10, 32'h4);
      wr(8'h08, 32'h10);
      wr(8'h00, 32'h1E);
      settle();
      chk("all_clear", 32'h0, 32'(irq));
      wr(8'h08, 32'h100);
      rdc("hist_pop", 8'h08, 32'h07);
      $display("test history done");
      go(2'd0, 2'd3, 3);
      go(2'd2, 2'd3, 10);
      go(2'd2, 2'd0, 3);
      go(2'd2, 2'd1, 3 * BC);
      go(2'd2, 2'd2, 4 * BC);
      bus(1'b1);
      go(2'd2, 2'd1, 2 * FB * BC);
      bus(1'b0);
      go(2'd2, 2'd0, 2 * BC);
      go(2'd2, 2'd2, 4 * BC);
      go(2'd2, 2'd0, 2 * BC);
      bus(1'b1);
      go(2'd1, 2'd0, 3 * FB * BC);
      bus(1'b0);
      go(2'd2, 2'd0, 3);
      go(2'd0, 2'd0, 2 * BC);
      go(2'd0, 2'd3, 3);
      go(2'd3, 2'd3, 3);
      $display("test modes done");
      report_and_stop();
   end

   // Bounds the whole run, well beyond the fewer than one thousand cycles used
   initial begin
      repeat (20000) @(posedge clk_in);
      miscompares++;
      report_and_stop();
   end
endmodule : tb_can_irq_sources_mode_timing
